// ---- rpp_phy_model.sv ----
// Behavioural reduced-pin PHY for one port: sends queued nibbles as dibits.
// Assumes the bench fills send_q and reads got_q, both as whole nibbles.
`timescale 1ns/10ps
`default_nettype none
module rpp_phy_model
   import rpp_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic tx_enable_i,
   input wire logic [1:0] tx_data_i,
   output rpp_dibit_type rx_o
);
   logic [3:0] send_q[$];
   logic [3:0] got_q[$];
   logic [3:0] cur;
   logic [1:0] lo;
   logic hi_next = 1'b0;
   logic half = 1'b0;
   initial rx_o = '0;
   // Idle data toggles, so a stale dibit can never pass for fresh data.
   always @(negedge ref_clk_i) begin
      if (hi_next) begin
         rx_o <= {2'b10, cur[3:2]};
         hi_next <= 1'b0;
      end else if (send_q.size() > 0) begin
         cur = send_q.pop_front();
         rx_o <= {2'b10, cur[1:0]};
         hi_next <= 1'b1;
      end else begin
         rx_o <= {2'b00, ~rx_o.data};
      end
   end
   always @(posedge ref_clk_i) begin
      if (!tx_enable_i) begin
         half = 1'b0;
      end else if (half) begin
         got_q.push_back({tx_data_i, lo});
         half = 1'b0;
      end else begin
         lo = tx_data_i;
         half = 1'b1;
      end
   end
endmodule : rpp_phy_model
`default_nettype wire

// ---- rpp_phy_port.sv ----
// PHY port of the frame logic: reduced-pin (two ports, 50 MHz reference) or
// reduced-gigabit at 100 Mbit/s through integrator-supplied DDR cells.
// Assumes the link clock is the 50 MHz reference or the main 25 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module rpp_phy_port
   import rpp_pkg::*;
#(
   parameter rpp_mode_type MODE = RPP_MODE_REDUCED,
   parameter int NUM_PORTS = RPP_REDUCED_PORTS,
   parameter int RST_HOLD_CYC = RPP_PHY_RST_HOLD_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic link_clk_i,
   input wire logic core_clock_shifted_i,
   input wire logic [NUM_PORTS-1:0] reduced_port_link_up_n_i,
   input wire logic [NUM_PORTS-1:0] gig_port_link_up_n_i,
   input wire logic mi_link_sel_i,
   input wire logic [NUM_PORTS-1:0] mi_link_up_i,
   input wire logic fiber_mode_i,
   input wire logic enh_link_det_i,
   output logic [NUM_PORTS-1:0] link_up_o,
   output logic phy_reset_n_out_o,
   input wire rpp_dibit_type [NUM_PORTS-1:0] reduced_rx_i,
   output logic [NUM_PORTS-1:0] reduced_tx_enable_o,
   output logic [NUM_PORTS-1:0][1:0] reduced_tx_data_o,
   output logic rx_ddr_cell_clock_o,
   output logic rx_ddr_cell_reset_n_o,
   input wire logic [NUM_PORTS-1:0] rx_ctl_low_half_i,
   input wire logic [NUM_PORTS-1:0] rx_ctl_high_half_i,
   input wire logic [NUM_PORTS-1:0][3:0] rx_data_low_half_i,
   input wire logic [NUM_PORTS-1:0][3:0] rx_data_high_half_i,
   output logic txclk_ddr_cell_clock_o,
   output logic txclk_ddr_cell_reset_n_o,
   output logic [NUM_PORTS-1:0] txclk_low_half_o,
   output logic [NUM_PORTS-1:0] txclk_high_half_o,
   output logic tx_ddr_cell_clock_o,
   output logic tx_ddr_cell_reset_n_o,
   output logic [NUM_PORTS-1:0] tx_ctl_low_half_o,
   output logic [NUM_PORTS-1:0] tx_ctl_high_half_o,
   output logic [NUM_PORTS-1:0][3:0] tx_data_low_half_o,
   output logic [NUM_PORTS-1:0][3:0] tx_data_high_half_o,
   output rpp_rx_type [NUM_PORTS-1:0] core_rx_o,
   input wire rpp_tx_type [NUM_PORTS-1:0] core_tx_i,
   output logic [NUM_PORTS-1:0] core_tx_ready_o
);
   localparam bit IS_GIG = (MODE == RPP_MODE_GIG);
   localparam int CW = $clog2(RST_HOLD_CYC + 1);

   if ((!IS_GIG && NUM_PORTS != RPP_REDUCED_PORTS) ||
       (IS_GIG && (NUM_PORTS < RPP_GIG_MIN_PORTS ||
                   NUM_PORTS > RPP_GIG_MAX_PORTS)) ||
       RST_HOLD_CYC < 1) begin : g_bad_cfg
      $error("rpp_phy_port: unsupported port count or hold count");
   end

   // Cell clocks are forwarded, not registered: a clock must not pass a
   // flip-flop, so these three outputs are the one exception to flop outputs.
   assign rx_ddr_cell_clock_o = link_clk_i;
   assign tx_ddr_cell_clock_o = link_clk_i;
   assign txclk_ddr_cell_clock_o = core_clock_shifted_i;

   // System domain: link status and PHY reset.
   logic [NUM_PORTS-1:0] link_meta_r;
   logic [NUM_PORTS-1:0] link_sync_r;
   logic [NUM_PORTS-1:0] link_up_nxt;
   logic [NUM_PORTS-1:0] link_pin_n;
   logic [NUM_PORTS-1:0] link_up_r;
   logic link_lost;
   rpp_prst_type prst_r;
   rpp_prst_type prst_nxt;
   logic [CW-1:0] hold_cnt_r;
   logic [CW-1:0] hold_cnt_nxt;
   logic phy_rst_n_r;

   assign link_pin_n = IS_GIG ? gig_port_link_up_n_i : reduced_port_link_up_n_i;
   assign link_up_nxt = mi_link_sel_i ? mi_link_up_i : ~link_sync_r;
   assign link_lost = fiber_mode_i && enh_link_det_i &&
                      |(link_up_r & ~link_up_nxt);
   assign prst_nxt = link_lost ? RPP_PRST_ACTIVE :
                     (prst_r == RPP_PRST_ACTIVE && hold_cnt_r > CW'(1)) ?
                     RPP_PRST_ACTIVE : RPP_PRST_RUN;
   assign hold_cnt_nxt = link_lost ? CW'(RST_HOLD_CYC) :
                         (hold_cnt_r != '0) ? hold_cnt_r - CW'(1) : '0;

   always_ff @(posedge sys_clk_i) begin
      link_meta_r <= link_pin_n;
      link_sync_r <= link_meta_r;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         link_up_r <= '0;
         prst_r <= RPP_PRST_RUN;
         hold_cnt_r <= '0;
         phy_rst_n_r <= RPP_PHY_RST_N_RST;
      end else begin
         link_up_r <= link_up_nxt;
         prst_r <= prst_nxt;
         hold_cnt_r <= hold_cnt_nxt;
         phy_rst_n_r <= (prst_nxt == RPP_PRST_RUN);
      end
   end

   assign link_up_o = link_up_r;
   assign phy_reset_n_out_o = phy_rst_n_r;

   // Link domain: reset crossing, then the cell reset outputs.
   logic lrst_meta_r;
   logic lrst_n_r;
   logic cell_rst_n_r;

   always_ff @(posedge link_clk_i) begin
      lrst_meta_r <= rst_b_i;
      lrst_n_r <= lrst_meta_r;
   end

   always_ff @(posedge link_clk_i) begin
      if (!lrst_n_r) begin
         cell_rst_n_r <= RPP_CELL_RST_N_RST;
      end else begin
         cell_rst_n_r <= IS_GIG;
      end
   end

   assign rx_ddr_cell_reset_n_o = cell_rst_n_r;
   assign txclk_ddr_cell_reset_n_o = cell_rst_n_r;
   assign tx_ddr_cell_reset_n_o = cell_rst_n_r;

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      rpp_dibit_type cap_r;
      logic rx_half_r;
      logic [1:0] rx_low_r;
      logic rx_err_r;
      rpp_rx_type rx_r;
      logic tx_phase_r;
      logic [1:0] tx_hold_r;
      logic tx_ready_r;
      logic rtx_en_r;
      logic [1:0] rtx_data_r;
      logic gctl_h_r;
      logic gctl_l_r;
      logic [3:0] gdata_r;
      logic gclk_h_r;
      logic gclk_l_r;
      logic take;
      logic gig_err;

      assign take = core_tx_i[p].en && tx_ready_r;
      assign gig_err = rx_ctl_low_half_i[p] ^ rx_ctl_high_half_i[p];

      always_ff @(posedge link_clk_i) begin
         if (!lrst_n_r) begin
            cap_r <= '0;
            rx_half_r <= 1'b0;
            rx_low_r <= '0;
            rx_err_r <= 1'b0;
            rx_r <= '0;
            tx_phase_r <= 1'b0;
            tx_hold_r <= '0;
            tx_ready_r <= 1'b0;
            rtx_en_r <= 1'b0;
            rtx_data_r <= '0;
            gctl_h_r <= 1'b0;
            gctl_l_r <= 1'b0;
            gdata_r <= '0;
            gclk_h_r <= 1'b0;
            gclk_l_r <= 1'b0;
         end else if (IS_GIG) begin
            // Receive: high control half is valid, low xor high is error.
            rx_r <= '{valid: rx_ctl_high_half_i[p], err: gig_err,
                      data: rx_data_low_half_i[p]};
            tx_ready_r <= 1'b1;
            gctl_h_r <= core_tx_i[p].en;
            gctl_l_r <= core_tx_i[p].en ^ core_tx_i[p].err;
            gdata_r <= core_tx_i[p].data;
            gclk_h_r <= RPP_TXCLK_HIGH_VAL;
            gclk_l_r <= RPP_TXCLK_LOW_VAL;
         end else begin
            cap_r <= reduced_rx_i[p];
            if (!cap_r.valid) begin
               rx_half_r <= 1'b0;
               rx_r <= '0;
            end else if (!rx_half_r) begin
               rx_half_r <= 1'b1;
               rx_low_r <= cap_r.data;
               rx_err_r <= cap_r.err;
               rx_r <= '0;
            end else begin
               // The first dibit of a pair is the low half of the nibble.
               rx_half_r <= 1'b0;
               rx_r <= '{valid: 1'b1, err: rx_err_r | cap_r.err,
                         data: {cap_r.data, rx_low_r}};
            end
            // Each nibble takes two reference cycles, so ready drops for one.
            if (tx_phase_r) begin
               rtx_en_r <= 1'b1;
               rtx_data_r <= tx_hold_r;
               tx_phase_r <= 1'b0;
               tx_ready_r <= 1'b1;
            end else begin
               rtx_en_r <= take;
               rtx_data_r <= take ? core_tx_i[p].data[RPP_DIBIT_LO +: 2] : '0;
               tx_hold_r <= core_tx_i[p].data[RPP_DIBIT_HI +: 2];
               tx_phase_r <= take;
               tx_ready_r <= !take;
            end
         end
      end

      assign core_rx_o[p] = rx_r;
      assign core_tx_ready_o[p] = tx_ready_r;
      assign reduced_tx_enable_o[p] = rtx_en_r;
      assign reduced_tx_data_o[p] = rtx_data_r;
      assign tx_ctl_high_half_o[p] = gctl_h_r;
      assign tx_ctl_low_half_o[p] = gctl_l_r;
      assign tx_data_low_half_o[p] = gdata_r;
      assign tx_data_high_half_o[p] = gdata_r;
      assign txclk_high_half_o[p] = gclk_h_r;
      assign txclk_low_half_o[p] = gclk_l_r;

      if (IS_GIG) begin : g_gig_chk
         a_gig_halves_same: assert property (
            @(posedge link_clk_i) disable iff (!lrst_n_r)
            ##1 (tx_data_low_half_o[p] == $past(core_tx_i[p].data) &&
            tx_data_high_half_o[p] == $past(core_tx_i[p].data)))
            else $error("transmit halves differ");
         a_gig_ctl_halves: assert property (
            @(posedge link_clk_i) disable iff (!lrst_n_r)
            ##1 (tx_ctl_high_half_o[p] == $past(core_tx_i[p].en) &&
            tx_ctl_low_half_o[p] ==
            ($past(core_tx_i[p].en) ^ $past(core_tx_i[p].err))))
            else $error("transmit control halves wrong");
         a_gig_rx_error: assert property (
            @(posedge link_clk_i) disable iff (!lrst_n_r)
            $past(lrst_n_r) |-> core_rx_o[p].err ==
            $past(rx_ctl_low_half_i[p] ^ rx_ctl_high_half_i[p]))
            else $error("receive error not low xor high");
      end else begin : g_red_chk
         a_red_tx_dibits: assert property (
            @(posedge link_clk_i) disable iff (!lrst_n_r)
            take |=> (reduced_tx_enable_o[p] &&
            reduced_tx_data_o[p] == $past(core_tx_i[p].data[1:0]))
            ##1 (reduced_tx_enable_o[p] &&
            reduced_tx_data_o[p] == $past(core_tx_i[p].data[3:2], 2)))
            else $error("reduced transmit dibits out of order");
         a_red_rx_pair: assert property (
            @(posedge link_clk_i) disable iff (!lrst_n_r)
            core_rx_o[p].valid |-> $past(reduced_rx_i[p].valid, 2) &&
            $past(reduced_rx_i[p].valid, 3) &&
            core_rx_o[p].data[3:2] == $past(reduced_rx_i[p].data, 2))
            else $error("reduced receive nibble without two dibits");
         // An error on either dibit spoils the whole nibble it belongs to.
         a_red_rx_error: assert property (
            @(posedge link_clk_i) disable iff (!lrst_n_r)
            core_rx_o[p].valid |-> core_rx_o[p].err ==
            ($past(reduced_rx_i[p].err, 2) | $past(reduced_rx_i[p].err, 3)))
            else $error("reduced receive error not merged");
      end
   end

   a_link_polarity: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (!$past(mi_link_sel_i) && $past(rst_b_i)) |->
      link_up_o == ~$past(link_pin_n, 3))
      else $error("link status polarity wrong");
   a_phy_rst_reset: assert property (
      @(posedge sys_clk_i) !rst_b_i |=> !phy_reset_n_out_o)
      else $error("PHY reset not driven during reset");
   a_phy_rst_loss: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      link_lost |=> !phy_reset_n_out_o && hold_cnt_r == CW'(RST_HOLD_CYC))
      else $error("PHY reset not driven on fiber link loss");
   a_phy_rst_release: assert property (
      @(posedge sys_clk_i) disable iff (!rst_b_i)
      (hold_cnt_r == CW'(1) && !link_lost) |=> phy_reset_n_out_o)
      else $error("PHY reset held too long");
   a_cell_reset: assert property (
      @(posedge link_clk_i) !lrst_n_r |=> !tx_ddr_cell_reset_n_o &&
      !rx_ddr_cell_reset_n_o && !txclk_ddr_cell_reset_n_o)
      else $error("DDR cell reset not asserted");
endmodule : rpp_phy_port
`default_nettype wire

// ---- rpp_phy_port_tb.sv ----
// Bench of the PHY port: a reduced-pin build with PHY models and a
// three-port reduced-gigabit build driven directly by the bench.
`timescale 1ns/10ps
`default_nettype none
module rpp_phy_port_tb;
   import rpp_pkg::*;
   localparam int HOLD = 4;
   logic sys_clk_i = 1'b0;
   logic lclk = 1'b0;
   wire sclk;
   logic rst_b_i = 1'b0;
   logic mi_sel = 1'b0;
   logic fiber = 1'b0;
   logic enh = 1'b0;
   logic [1:0] rlink_n = 2'h3;
   logic [2:0] glink_n = 3'h7;
   logic [2:0] mi_up = 3'h0;
   logic [2:0] grl = 3'h0;
   logic [2:0] grh = 3'h0;
   logic [2:0][3:0] grdl = '0;
   logic [2:0][3:0] grdh = '0;
   rpp_tx_type [1:0] rtx = '0;
   rpp_tx_type [2:0] gtx = '0;
   logic [1:0] rup, ren, rrdy;
   logic [2:0] gup, grdy, gtl, gth, gcl, gch;
   logic rprst, gprst;
   logic [1:0][1:0] rtd;
   logic [2:0][3:0] gdl, gdh;
   wire [2:0] rcr, gcr, gck;
   wire rpp_dibit_type [1:0] rxp;
   rpp_rx_type [1:0] rrx;
   rpp_rx_type [2:0] grx;
   int n_errors = 0;
   int cmp_count = 0;
   int seed = 42974;

   always #2 sys_clk_i = ~sys_clk_i;
   initial begin
      #1.3;
      forever #6 lclk = ~lclk;
   end
   assign #2 sclk = lclk;

   rpp_phy_model phy0 (.ref_clk_i(lclk), .tx_enable_i(ren[0]),
      .tx_data_i(rtd[0]), .rx_o(rxp[0]));
   rpp_phy_model phy1 (.ref_clk_i(lclk), .tx_enable_i(ren[1]),
      .tx_data_i(rtd[1]), .rx_o(rxp[1]));

   rpp_phy_port #(.MODE(RPP_MODE_REDUCED), .NUM_PORTS(2),
      .RST_HOLD_CYC(HOLD)) dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .link_clk_i(lclk), .core_clock_shifted_i(sclk),
      .reduced_port_link_up_n_i(rlink_n), .gig_port_link_up_n_i(glink_n[1:0]),
      .mi_link_sel_i(mi_sel), .mi_link_up_i(mi_up[1:0]),
      .fiber_mode_i(fiber), .enh_link_det_i(enh), .link_up_o(rup),
      .phy_reset_n_out_o(rprst), .reduced_rx_i(rxp),
      .reduced_tx_enable_o(ren), .reduced_tx_data_o(rtd),
      .rx_ddr_cell_clock_o(), .rx_ddr_cell_reset_n_o(rcr[0]),
      .rx_ctl_low_half_i(grl[1:0]), .rx_ctl_high_half_i(grh[1:0]),
      .rx_data_low_half_i(grdl[1:0]), .rx_data_high_half_i(grdh[1:0]),
      .txclk_ddr_cell_clock_o(), .txclk_ddr_cell_reset_n_o(rcr[1]),
      .txclk_low_half_o(), .txclk_high_half_o(), .tx_ddr_cell_clock_o(),
      .tx_ddr_cell_reset_n_o(rcr[2]), .tx_ctl_low_half_o(),
      .tx_ctl_high_half_o(), .tx_data_low_half_o(), .tx_data_high_half_o(),
      .core_rx_o(rrx), .core_tx_i(rtx), .core_tx_ready_o(rrdy));

   rpp_phy_port #(.MODE(RPP_MODE_GIG), .NUM_PORTS(3),
      .RST_HOLD_CYC(HOLD)) dut_g (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .link_clk_i(lclk), .core_clock_shifted_i(sclk),
      .reduced_port_link_up_n_i({1'b1, rlink_n}),
      .gig_port_link_up_n_i(glink_n), .mi_link_sel_i(mi_sel),
      .mi_link_up_i(mi_up), .fiber_mode_i(fiber), .enh_link_det_i(enh),
      .link_up_o(gup), .phy_reset_n_out_o(gprst),
      .reduced_rx_i({rxp[0], rxp}), .reduced_tx_enable_o(),
      .reduced_tx_data_o(), .rx_ddr_cell_clock_o(gck[0]),
      .rx_ddr_cell_reset_n_o(gcr[0]), .rx_ctl_low_half_i(grl),
      .rx_ctl_high_half_i(grh), .rx_data_low_half_i(grdl),
      .rx_data_high_half_i(grdh), .txclk_ddr_cell_clock_o(gck[1]),
      .txclk_ddr_cell_reset_n_o(gcr[1]), .txclk_low_half_o(gtl),
      .txclk_high_half_o(gth), .tx_ddr_cell_clock_o(gck[2]),
      .tx_ddr_cell_reset_n_o(gcr[2]), .tx_ctl_low_half_o(gcl),
      .tx_ctl_high_half_o(gch), .tx_data_low_half_o(gdl),
      .tx_data_high_half_o(gdh), .core_rx_o(grx), .core_tx_i(gtx),
      .core_tx_ready_o(grdy));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task conclude;
      $display("comparisons %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude

   function automatic logic [29:0] gtx_exp(input rpp_tx_type [2:0] t);
      logic [29:0] r;
      for (int p = 0; p < 3; p++) begin
         r[27+p] = t[p].en;
         r[24+p] = t[p].en ^ t[p].err;
         r[12+4*p +: 4] = t[p].data;
         r[4*p +: 4] = t[p].data;
      end
      return r;
   endfunction : gtx_exp

   function automatic logic [17:0] grx_exp(input logic [2:0] l, h,
         input logic [11:0] d);
      logic [17:0] r;
      for (int p = 0; p < 3; p++) r[6*p +: 6] = {h[p], l[p] ^ h[p], d[4*p +: 4]};
      return r;
   endfunction : grx_exp

   initial begin
      #100000;
      n_errors++;
      conclude();
   end

   initial begin
      int n;
      int k;
      logic [31:0] rv;
      logic [3:0] e0[$];
      logic [3:0] e1[$];
      repeat (6) @(negedge lclk);
      chk({rprst, gprst, rup, gup}, 32'h0);
      @(negedge sys_clk_i);
      rst_b_i = 1'b1;
      repeat (5) @(negedge lclk);
      chk({rcr, gcr, gth, gtl}, 32'h1f8);
      for (int i = 0; i < 8; i++) begin
         @(negedge sys_clk_i);
         chk(gck, {lclk, sclk, lclk});
         rv = $random(seed);
         rlink_n = rv[1:0];
         glink_n = rv[4:2];
         enh = rv[5];
         repeat (4) @(negedge sys_clk_i);
         chk({rup, gup}, 5'(~{rlink_n, glink_n}));
         chk({rprst, gprst}, 32'h3);
      end
      rlink_n = 2'h0;
      glink_n = 3'h0;
      mi_sel = 1'b1;
      mi_up = rv[8:6];
      repeat (4) @(negedge sys_clk_i);
      chk({rup, gup}, {mi_up[1:0], mi_up});
      mi_sel = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      fiber = 1'b1;
      enh = 1'b1;
      @(negedge sys_clk_i);
      rlink_n = 2'h2;
      k = 0;
      while (rprst !== 1'b0 && k < 10) begin
         @(negedge sys_clk_i);
         k++;
      end
      n = 0;
      while (rprst === 1'b0 && n < 50) begin
         @(negedge sys_clk_i);
         n++;
      end
      chk(n, HOLD);
      chk(gprst, 1'b1);
      enh = 1'b0;
      rlink_n = 2'h0;
      repeat (4) @(negedge sys_clk_i);
      rlink_n = 2'h1;
      repeat (8) @(negedge sys_clk_i);
      chk(rprst, 1'b1);
      @(negedge lclk);
      for (int i = 0; i < 6; i++) begin
         k = 0;
         while (rrdy !== 2'h3 && k < 10) begin
            @(negedge lclk);
            k++;
         end
         chk(rrdy, 32'h3);
         rv = $random(seed);
         rtx = {1'b1, rv[0], rv[4:1], 1'b1, rv[5], rv[9:6]};
         e1.push_back(rv[4:1]);
         e0.push_back(rv[9:6]);
         @(negedge lclk);
      end
      rtx = '0;
      repeat (6) @(negedge lclk);
      chk(phy0.got_q.size(), 32'd6);
      chk(phy1.got_q.size(), 32'd6);
      for (int i = 0; i < 6; i++) begin
         chk({phy0.got_q[i], phy1.got_q[i]}, {e0[i], e1[i]});
      end
      @(posedge lclk);
      e0.delete();
      e1.delete();
      for (int i = 0; i < 5; i++) begin
         rv = $random(seed);
         phy0.send_q.push_back(rv[3:0]);
         phy1.send_q.push_back(rv[7:4]);
         e0.push_back(rv[3:0]);
         e1.push_back(rv[7:4]);
      end
      for (int i = 0; i < 40; i++) begin
         @(negedge lclk);
         if (rrx[0].valid === 1'b1) chk(rrx[0], {2'b10, e0.pop_front()});
         if (rrx[1].valid === 1'b1) chk(rrx[1], {2'b10, e1.pop_front()});
      end
      chk(e0.size() + e1.size(), 32'h0);
      for (int i = 0; i < 16; i++) begin
         @(negedge lclk);
         rv = $random(seed);
         gtx = rv[17:0];
         grl = rv[20:18];
         grh = rv[23:21];
         rv = $random(seed);
         grdl = rv[11:0];
         grdh = grdl;
         @(negedge lclk);
         chk({gch, gcl, gdh, gdl}, gtx_exp(gtx));
         chk(grx, grx_exp(grl, grh, grdl));
         chk(grdy, 32'h7);
      end
      conclude();
   end
endmodule : rpp_phy_port_tb
`default_nettype wire

// ---- rpp_pkg.sv ----
// Shared constants and carrier types of the reduced-pin / reduced-gigabit
// PHY port. Assumes a 250 MHz system clock and one link clock per build.
package rpp_pkg;
   typedef enum logic {RPP_MODE_REDUCED, RPP_MODE_GIG} rpp_mode_type;
   typedef enum logic {RPP_PRST_RUN, RPP_PRST_ACTIVE} rpp_prst_type;

   localparam int RPP_REDUCED_PORTS = 2;
   localparam int RPP_GIG_MIN_PORTS = 1;
   localparam int RPP_GIG_MAX_PORTS = 3;
   localparam int RPP_REF_CLK_MHZ = 50;
   localparam int RPP_CORE_CLK_MHZ = 25;
   localparam int RPP_SHIFT_NS = 2;
   localparam int RPP_LINK_MBPS = 100;
   localparam int RPP_SYS_CLK_MHZ = 250;
   localparam int RPP_SYNC_STAGES = 2;
   // Least hold time of the PHY reset after a lost fiber link.
   localparam int RPP_PHY_RST_HOLD_NS = 10000;
   localparam int RPP_PHY_RST_HOLD_CYC =
      (RPP_PHY_RST_HOLD_NS * RPP_SYS_CLK_MHZ + 999) / 1000;
   localparam logic RPP_PHY_RST_N_RST = 1'b0;
   localparam logic RPP_CELL_RST_N_RST = 1'b0;
   localparam logic RPP_TXCLK_HIGH_VAL = 1'b1;
   localparam logic RPP_TXCLK_LOW_VAL = 1'b0;
   localparam int RPP_DIBIT_LO = 0;
   localparam int RPP_DIBIT_HI = 2;

   typedef struct packed {
      logic valid;
      logic err;
      logic [3:0] data;
   } rpp_rx_type;

   typedef struct packed {
      logic en;
      logic err;
      logic [3:0] data;
   } rpp_tx_type;

   typedef struct packed {
      logic valid;
      logic err;
      logic [1:0] data;
   } rpp_dibit_type;
endpackage : rpp_pkg
